// File: svfs_pkg.sv
// shared constants and types of the servo fault supervisor
package svfs_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // clock and display timing
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned MS_PER_S       = 1000;
  localparam int unsigned DISP_PERIOD_MS = 1000;
  localparam int unsigned DISP_CYCLES    = CLK_HZ / MS_PER_S * DISP_PERIOD_MS;

  //////////////////////////////////////////////////////////////////////////////
  // measurement width and trip ratios
  localparam int unsigned MEAS_W = 16;
  localparam logic [3:0]  OC_NUM = 4'h5;
  localparam logic [3:0]  OC_DEN = 4'h2;
  localparam logic [3:0]  OS_NUM = 4'h5;
  localparam logic [3:0]  OS_DEN = 4'h4;

  //////////////////////////////////////////////////////////////////////////////
  // fault codes and condition vector layout
  localparam int unsigned N_FAULT       = 14;
  localparam logic [4:0]  CODE_NONE     = 5'h00;
  localparam logic [4:0]  CODE_FIRST    = 5'h05;
  localparam logic [4:0]  CODE_CHECKSUM = 5'h0d;
  localparam logic [4:0]  CODE_COMM     = 5'h0e;
  localparam logic [4:0]  CODE_SW_LIM   = 5'h11;
  localparam logic [4:0]  CODE_HW_LIM   = 5'h12;
  localparam logic [4:0]  CODE_TEN      = 5'h0a;
  localparam int unsigned IDX_OC        = 0;
  localparam int unsigned IDX_BALLAST   = 1;
  localparam int unsigned IDX_AMP_TEMP  = 2;
  localparam int unsigned IDX_MOT_TEMP  = 3;
  localparam int unsigned IDX_ENCODER   = 4;
  localparam int unsigned IDX_OS        = 5;
  localparam int unsigned IDX_OVERRANGE = 6;
  localparam int unsigned IDX_GROUND    = 7;
  localparam int unsigned IDX_CHECKSUM  = 8;
  localparam int unsigned IDX_COMM      = 9;
  localparam int unsigned IDX_HW_EN     = 10;
  localparam int unsigned IDX_INPUT_OC  = 11;
  localparam int unsigned IDX_SW_LIM    = 12;
  localparam int unsigned IDX_HW_LIM    = 13;
  localparam logic [13:0] LIMIT_MASK    = 14'h3000;
  localparam logic [7:0]  FAULT_LETTER  = 8'h46;

  //////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [3:0] {
    ST_RUN  = 4'b0001,
    ST_TRIP = 4'b0010,
    ST_STOP = 4'b0100,
    ST_LOCK = 4'b1000
  } svfs_state_e;

  typedef struct packed {
    logic [MEAS_W-1:0] out_current;
    logic [MEAS_W-1:0] rated_current;
    logic [MEAS_W-1:0] shaft_speed;
    logic [MEAS_W-1:0] max_speed;
    logic              ballast_ovl;
    logic              amp_overtemp;
    logic              motor_overtemp;
    logic              enc_break;
    logic              enc_init_fail;
    logic              cur_overrange;
    logic              ground_fault;
    logic              checksum_fail;
    logic              comm_fail;
    logic              input_overcurrent;
    logic              sw_limit_outside;
    logic              hw_limit_tripped;
  } svfs_mon_s;

  typedef struct packed {
    logic [7:0] letter;
    logic [3:0] tens;
    logic [3:0] ones;
    logic       strobe;
  } svfs_disp_s;

  typedef struct packed {
    svfs_state_e st;
    logic [4:0]  code;
    logic        hw_defect;
    logic        sw_armed;
    logic        hw_armed;
    logic        power;
    logic        torque_stop;
    svfs_disp_s  disp;
  } svfs_state_s;

endpackage

// File: svfs_tick_gen.sv
// periodic one-cycle enable pulse for the display refresh
module svfs_tick_gen #(
  parameter int unsigned PERIOD = 40_000_000
) (
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  output logic      tick_out
);

  localparam int unsigned CNT_W = $clog2(PERIOD);

  logic [CNT_W-1:0] cnt_q;
  logic             tick_q;

  initial
  begin
    if (PERIOD < 2)
      $error("svfs_tick_gen: PERIOD must be at least 2");
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end
    else if (cnt_q == CNT_W'(PERIOD - 1))
    begin
      cnt_q  <= '0;
      tick_q <= 1'b1;
    end
    else
    begin
      cnt_q  <= cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  assign tick_out = tick_q;

endmodule

// File: svfs_supervisor.sv
// fault supervisor: latches fault codes, picks reaction, drives display
module svfs_supervisor
  import svfs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = DISP_CYCLES
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  input  wire svfs_pkg::svfs_mon_s mon_in,
  input  wire logic             sw_enable_in,
  input  wire logic             hw_enable_in,
  input  wire logic             ack_in,
  output logic                  power_enable_out,
  output logic                  torque_stop_out,
  output logic                  fault_active_out,
  output logic                  locked_out,
  output logic [4:0]            err_code_out,
  output logic                  hw_defect_out,
  output svfs_pkg::svfs_disp_s  disp_out
);

  import svfs_pkg::*;

  initial
  begin
    if (TICK_CYCLES < 2)
      $error("svfs_supervisor: TICK_CYCLES must be at least 2");
  end

  //////////////////////////////////////////////////////////////////////////////
  // functions

  // val * den > lim * num without overflow
  function automatic logic ratio_exceeds(input logic [MEAS_W-1:0] val,
                                         input logic [MEAS_W-1:0] lim,
                                         input logic [3:0]        num,
                                         input logic [3:0]        den);
    logic [MEAS_W+3:0] lhs;
    logic [MEAS_W+3:0] rhs;
    lhs = val * den;
    rhs = lim * num;
    return lhs > rhs;
  endfunction

  // lowest set condition gives the code
  function automatic logic [4:0] first_code(input logic [N_FAULT-1:0] c);
    logic [4:0] r;
    r = CODE_NONE;
    for (int i = N_FAULT - 1; i >= 0; i--)
    begin
      if (c[i])
        r = CODE_FIRST + 5'(i);
    end
    return r;
  endfunction

  // reaction chosen by code
  function automatic svfs_state_e reaction(input logic [4:0] code);
    svfs_state_e r;
    r = ST_TRIP;
    if (code == CODE_CHECKSUM || code == CODE_COMM)
      r = ST_LOCK;
    else if (code == CODE_SW_LIM || code == CODE_HW_LIM)
      r = ST_STOP;
    return r;
  endfunction

  // source condition of a latched code still present
  function automatic logic src_present(input logic [N_FAULT-1:0] c,
                                       input logic [4:0]         code);
    logic [4:0] idx;
    idx = code - CODE_FIRST;
    return c[idx[3:0]];
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // condition vector

  svfs_state_s        q;
  svfs_state_s        n;
  logic [N_FAULT-1:0] cond;
  logic [4:0]         first_c;
  logic               tick;

  always_comb
  begin
    cond = '0;
    cond[IDX_OC]        = ratio_exceeds(mon_in.out_current, mon_in.rated_current,
                                        OC_NUM, OC_DEN);
    cond[IDX_BALLAST]   = mon_in.ballast_ovl;
    cond[IDX_AMP_TEMP]  = mon_in.amp_overtemp;
    cond[IDX_MOT_TEMP]  = mon_in.motor_overtemp;
    cond[IDX_ENCODER]   = mon_in.enc_break | mon_in.enc_init_fail;
    cond[IDX_OS]        = ratio_exceeds(mon_in.shaft_speed, mon_in.max_speed,
                                        OS_NUM, OS_DEN);
    cond[IDX_OVERRANGE] = mon_in.cur_overrange;
    cond[IDX_GROUND]    = mon_in.ground_fault;
    cond[IDX_CHECKSUM]  = mon_in.checksum_fail;
    cond[IDX_COMM]      = mon_in.comm_fail;
    cond[IDX_HW_EN]     = sw_enable_in & ~hw_enable_in;
    cond[IDX_INPUT_OC]  = mon_in.input_overcurrent;
    cond[IDX_SW_LIM]    = q.sw_armed & mon_in.sw_limit_outside;
    cond[IDX_HW_LIM]    = q.hw_armed & mon_in.hw_limit_tripped;
  end

  assign first_c = first_code(cond);

  //////////////////////////////////////////////////////////////////////////////
  // display refresh enable

  svfs_tick_gen #(
    .PERIOD (TICK_CYCLES)
  ) u_tick (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .tick_out   (tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    n             = q;
    n.disp.strobe = 1'b0;
    unique case (q.st)
      ST_RUN:
      begin
        if (|cond)
        begin
          n.code        = first_c;
          n.st          = reaction(first_c);
          n.hw_defect   = (reaction(first_c) == ST_LOCK);
          n.power       = (reaction(first_c) == ST_STOP);
          n.torque_stop = (reaction(first_c) == ST_STOP);
          if (first_c == CODE_SW_LIM)
            n.sw_armed = 1'b0;
          if (first_c == CODE_HW_LIM)
            n.hw_armed = 1'b0;
        end
        else
        begin
          n.power = sw_enable_in & hw_enable_in;
        end
      end
      ST_TRIP, ST_STOP:
      begin
        if (ack_in && !src_present(cond, q.code))
        begin
          n.st          = ST_RUN;
          n.code        = CODE_NONE;
          n.power       = 1'b0;
          n.torque_stop = 1'b0;
        end
      end
      ST_LOCK:
      begin
        n.power       = 1'b0;
        n.torque_stop = 1'b0;
      end
    endcase
    if (!q.sw_armed && !mon_in.sw_limit_outside)
      n.sw_armed = 1'b1;
    if (!q.hw_armed && !mon_in.hw_limit_tripped)
      n.hw_armed = 1'b1;
    if (tick && q.st != ST_RUN)
    begin
      n.disp.strobe = 1'b1;
      n.disp.letter = FAULT_LETTER;
      if (q.code >= CODE_TEN)
      begin
        n.disp.tens = 4'h1;
        n.disp.ones = 4'(q.code - CODE_TEN);
      end
      else
      begin
        n.disp.tens = 4'h0;
        n.disp.ones = q.code[3:0];
      end
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      q.st          <= ST_RUN;
      q.code        <= CODE_NONE;
      q.hw_defect   <= 1'b0;
      q.sw_armed    <= 1'b1;
      q.hw_armed    <= 1'b1;
      q.power       <= 1'b0;
      q.torque_stop <= 1'b0;
      q.disp        <= '0;
    end
    else
    begin
      q <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign power_enable_out = q.power;
  assign torque_stop_out  = q.torque_stop;
  assign fault_active_out = (q.st != ST_RUN);
  assign locked_out       = (q.st == ST_LOCK);
  assign err_code_out     = q.code;
  assign hw_defect_out    = q.hw_defect;
  assign disp_out         = q.disp;

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  logic run_now;
  logic off_fault;
  logic lim_only;
  logic waiting;
  assign run_now   = (q.st == ST_RUN);
  assign off_fault = |(cond & ~LIMIT_MASK);
  assign lim_only  = !off_fault && |(cond & LIMIT_MASK);
  assign waiting   = (q.st == ST_TRIP) || (q.st == ST_STOP);

  sequence s_ack_ok;
    waiting && ack_in && !src_present(cond, q.code);
  endsequence

  sequence s_ack_bad;
    waiting && ack_in && src_present(cond, q.code);
  endsequence

  sequence s_back_to_run;
    !fault_active_out && !power_enable_out && err_code_out == CODE_NONE;
  endsequence

  // power removal on fault
  a_trip_power_off: assert property (
    run_now && off_fault |=> !power_enable_out && fault_active_out && !torque_stop_out)
    else $error("power not removed on fault");

  // lowest code latched
  a_code_lowest: assert property (
    run_now && |cond |=> err_code_out == $past(first_c) && err_code_out >= CODE_FIRST)
    else $error("wrong fault code latched");

  // code held while waiting
  a_code_held: assert property (
    waiting && !ack_in |=> $stable(err_code_out) && fault_active_out)
    else $error("latched code changed without acknowledge");

  // limit stop at torque
  a_limit_stop: assert property (
    run_now && lim_only |=> torque_stop_out && power_enable_out ##1 fault_active_out)
    else $error("limit trip did not stop at max torque");

  // software limit re-arm
  a_sw_rearm: assert property (
    !q.sw_armed && !mon_in.sw_limit_outside |=> q.sw_armed)
    else $error("software limit not re-armed");

  // hardware limit re-arm
  a_hw_rearm: assert property (
    !q.hw_armed && !mon_in.hw_limit_tripped |=> q.hw_armed)
    else $error("hardware limit not re-armed");

  // lock until reset
  a_lock_hold: assert property (
    locked_out |=> locked_out && hw_defect_out && !power_enable_out [*2])
    else $error("locked state left without reset");

  // acknowledge refused
  a_ack_refused: assert property (
    s_ack_bad |=> fault_active_out && $stable(err_code_out))
    else $error("acknowledge cleared a present fault");

  // acknowledge accepted
  a_ack_clears: assert property (
    s_ack_ok |=> s_back_to_run)
    else $error("acknowledge did not clear fault");

  // display refresh
  a_disp_refresh: assert property (
    tick && fault_active_out |=> disp_out.strobe && disp_out.letter == FAULT_LETTER
      && 5'(disp_out.tens) * CODE_TEN + 5'(disp_out.ones) == $past(err_code_out))
    else $error("fault indication not refreshed");

endmodule

// File: svfs_host_model.sv
// host motion controller model driving software enable and acknowledge
module svfs_host_model
(
  input  wire logic clk_sys_in,
  input  wire logic en_req_in,
  input  wire logic ack_req_in,
  input  wire logic force_in,
  input  wire logic hot_in,
  output logic      sw_enable_out,
  output logic      ack_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    sw_enable_out = 1'b0;
    ack_out       = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // enable drop, cool first
  // force_in breaks both on purpose
  always @(negedge clk_sys_in)
  begin
    sw_enable_out <= en_req_in & ~(ack_req_in & ~force_in);
    ack_out       <= ack_req_in & (force_in | (~sw_enable_out & ~hot_in));
  end
endmodule

// File: svfs_supervisor_bench.sv
// self-checking bench of the servo fault supervisor
module svfs_supervisor_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import svfs_pkg::*;

  localparam int unsigned TICKS = 8;
  logic       clk_sys, rst, hw_en, en_req, ack_req, force_ack, sw_en, ack;
  logic       power, tstop, fault, locked, hw_defect;
  logic [4:0] code;
  svfs_mon_s  mon;
  svfs_disp_s disp;
  int         mismatches = 0;
  int         compares = 0;
  logic [4:0] codes [14] = '{5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h09, 5'h0a,
                             5'h0b, 5'h0c, 5'h10, 5'h11, 5'h12, 5'h0d, 5'h0e};

  svfs_supervisor #(.TICK_CYCLES(TICKS)) i_svfs_supervisor (
    .clk_sys_in(clk_sys), .rst_in(rst), .mon_in(mon), .sw_enable_in(sw_en),
    .hw_enable_in(hw_en), .ack_in(ack), .power_enable_out(power),
    .torque_stop_out(tstop), .fault_active_out(fault), .locked_out(locked),
    .err_code_out(code), .hw_defect_out(hw_defect), .disp_out(disp));

  svfs_host_model i_svfs_host_model (
    .clk_sys_in(clk_sys), .en_req_in(en_req), .ack_req_in(ack_req), .force_in(force_ack),
    .hot_in(mon.amp_overtemp | mon.motor_overtemp), .sw_enable_out(sw_en), .ack_out(ack));

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic do_reset;
    rst = 1'b1;
    step(12);
    rst = 1'b0;
    step(1);
  endtask

  task automatic set_cond(input int k, input logic v);
    case (k)
      0: mon.rated_current = v ? 16'h0066 : 16'h0100;
      1: mon.ballast_ovl = v;
      2: mon.amp_overtemp = v;
      3: mon.motor_overtemp = v;
      4: mon.enc_break = v;
      5: mon.enc_init_fail = v;
      6: mon.max_speed = v ? 16'h00cc : 16'h0100;
      7: mon.cur_overrange = v;
      8: mon.ground_fault = v;
      9: mon.input_overcurrent = v;
      10: mon.sw_limit_outside = v;
      11: mon.hw_limit_tripped = v;
      12: mon.checksum_fail = v;
      default: mon.comm_fail = v;
    endcase
  endtask

  task automatic ack_fault(input logic f);
    force_ack <= f;
    ack_req <= 1'b1;
    step(4);
    ack_req <= 1'b0;
    force_ack <= 1'b0;
    step(2);
  endtask

  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    do_reset;
    chk({power, tstop, fault, locked, hw_defect, code}, 10'h000, "reset outputs");
    chk(disp, 17'h00000, "reset display");
    $display("reset test done");
  endtask

  task automatic t_codes;
    for (int k = 0; k < 10; k++)
    begin
      set_cond(k, 1'b1);
      step(1);
      chk(code, codes[k], "fault code");
      chk({fault, power, tstop}, 3'b100, "power removal");
      set_cond(k, 1'b0);
      ack_fault(1'b0);
      chk({fault, code}, 6'h00, "ack clears");
    end
    $display("code table test done");
  endtask

  task automatic t_lowest;
    mon.ground_fault = 1'b1;
    mon.ballast_ovl = 1'b1;
    step(1);
    chk(code, 5'h06, "lowest wins");
    set_cond(0, 1'b1);
    step(2);
    chk(code, 5'h06, "first code held");
    set_cond(0, 1'b0);
    mon.ground_fault = 1'b0;
    mon.ballast_ovl = 1'b0;
    ack_fault(1'b0);
    chk(code, 5'h00, "cleared");
    $display("priority test done");
  endtask

  task automatic t_refuse;
    mon.amp_overtemp = 1'b1;
    step(1);
    chk(code, 5'h07, "overtemp");
    ack_fault(1'b1);
    chk({fault, code}, 6'h27, "hot ack refused");
    mon.amp_overtemp = 1'b0;
    ack_fault(1'b0);
    chk({fault, code}, 6'h00, "cool ack taken");
    $display("refusal test done");
  endtask

  task automatic t_hw_en;
    hw_en = 1'b0;
    step(1);
    chk({power, code}, 6'h0f, "missing hw enable");
    ack_fault(1'b1);
    chk(code, 5'h0f, "ack with sw enable refused");
    en_req <= 1'b0;
    ack_fault(1'b0);
    chk(code, 5'h00, "ack after drop");
    hw_en = 1'b1;
    en_req <= 1'b1;
    step(3);
    chk(power, 1'b1, "power back");
    $display("hw enable test done");
  endtask

  task automatic t_limits;
    for (int k = 10; k < 12; k++)
    begin
      set_cond(k, 1'b1);
      step(1);
      chk(code, codes[k], "limit code");
      chk({fault, power, tstop}, 3'b111, "max torque stop");
      ack_fault(1'b0);
      step(3);
      chk({fault, code}, 6'h00, "disarmed while outside");
      set_cond(k, 1'b0);
      step(2);
      set_cond(k, 1'b1);
      step(1);
      chk(code, codes[k], "re-armed");
      set_cond(k, 1'b0);
      step(2);
      ack_fault(1'b0);
      chk(code, 5'h00, "limit cleared");
    end
    $display("limit test done");
  endtask

  task automatic t_lock;
    for (int k = 12; k < 14; k++)
    begin
      set_cond(k, 1'b1);
      step(1);
      chk({code, hw_defect, locked, power}, {codes[k], 3'b110}, "lock");
      set_cond(k, 1'b0);
      ack_fault(1'b0);
      chk({code, hw_defect, locked}, {codes[k], 2'b11}, "ack ignored");
      do_reset;
      chk({code, locked}, 6'h00, "reset recovers");
      step(3);
    end
    $display("lock test done");
  endtask

  task automatic t_disp;
    int n;
    mon.ground_fault = 1'b1;
    step(1);
    n = 0;
    while (disp.strobe !== 1'b1 && n < TICKS + 4)
    begin
      step(1);
      n++;
    end
    chk({disp.strobe, disp.letter, disp.tens, disp.ones}, 17'h14612, "display");
    n = 0;
    do
    begin
      step(1);
      n++;
    end
    while (disp.strobe !== 1'b1 && n < TICKS + 4);
    chk(n, TICKS, "refresh period");
    mon.ground_fault = 1'b0;
    ack_fault(1'b0);
    n = 0;
    repeat (TICKS + 2)
    begin
      step(1);
      if (disp.strobe !== 1'b0)
        n++;
    end
    chk(n, 0, "no strobe in run");
    $display("display test done");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial
  begin
    rst = 1'b1;
    hw_en = 1'b1;
    en_req = 1'b0;
    ack_req = 1'b0;
    force_ack = 1'b0;
    mon = '0;
    mon.out_current = 16'h0100;
    mon.rated_current = 16'h0100;
    mon.shaft_speed = 16'h0100;
    mon.max_speed = 16'h0100;
    t_reset;
    en_req <= 1'b1;
    step(3);
    t_codes;
    t_lowest;
    t_refuse;
    t_hw_en;
    t_limits;
    t_lock;
    t_disp;
    wrap_up;
  end

  initial
  begin
    repeat (4000) @(posedge clk_sys);
    mismatches++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    wrap_up;
  end
endmodule
